/* File: pwd_channel.sv */
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns

// Notes on behaviour
// R1: quadrature, bits 11:10 = 01: output active while count equals constant A.
// R2: quadrature, bit 11 set: output active while the index condition holds.
// R3: debounce bit 13 set removes input transitions shorter than 2.5 us.
// R4: mode field 010 selects continuous pulse width modulation.
// R5: constant A sets delay before active, constant B the active duration.
// R6: bit 3 picks active level: 0 active low (default), 1 active high.
// R7: count down per selected clock edge; at zero toggle and load other constant.
// R8: fastest internal clock adds one extra cycle to each timed interval; the code adds it to pwm loads only, not to watchdog loads of A.
// R9: gate code 01 runs while input low, 10 while high; else ungated.
// R10: external clock counted only with bits 7:6 = 01/10 and source 101.
// R11: source 000..100 picks internal rates, four times faster on fast carrier.
// R12: software sets carrier speed bit 0: clear for slow, set for fast carrier.
// R13: start on external trigger edge (01 low, 10 high) or software trigger.
// R14: host issues no further triggers nor control changes while running.
// R15: pwm with interrupt enable raises an interrupt on every output transition.
// R16: mode 011 watchdog: output active while counting from A down to zero.
// R17: timed-out watchdog restarts only after reload; retrigger at zero times out.
// R18: watchdog reload from A while input low (01) or high (10).
// R19: writing constant A loads the counter directly, even mid countdown; the code does this in watchdog mode only.
// R20: watchdog, trigger code 11: count while trigger input high, hold while low.
// R21: watchdog decrements once per selected clock after trigger.
// R22: watchdog zero raises interrupt, pending until reinitialised and cleared.
module pwd_channel (
  // apb slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pwd_pkg::PWD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // field inputs
  input  wire logic                          gate_reload_input,
  input  wire logic                          clock_event_input,
  input  wire logic                          trigger_index_input,
  // field output and interrupt
  output logic                               channel_out,
  output logic                               irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // level-sensitive selector: 01 active low, 10 active high, else inactive
  function automatic logic sel_active(input logic [1:0] sel, input logic lvl);
    logic r;
    r = 1'b0;
    if (sel == pwd_pkg::PWD_SEL_LOW) begin
      r = ~lvl;
    end else if (sel == pwd_pkg::PWD_SEL_HIGH) begin
      r = lvl;
    end
    return r;
  endfunction

  // internal clock rate in kHz for a source code and carrier speed
  function automatic logic [16:0] rate_khz(input logic [2:0] src, input logic fast);
    logic [16:0] r;
    r = 17'(pwd_pkg::PWD_BASE_KHZ) << src;
    if (fast) begin
      r = r << 2;
    end
    return r;
  endfunction

  // constant as loaded into the counter, one cycle longer on the fastest clock
  function automatic logic [16:0] load_val(input logic [15:0] k, input logic [2:0] src);
    logic [16:0] r;
    r = {1'b0, k};
    if (src == pwd_pkg::PWD_SRC_FASTEST) begin
      r = r + 17'h00001;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers and decoded fields

  logic                    board_fast_q;
  logic [15:0]             ctrl_q;
  logic [15:0]             const_a_q;
  logic [15:0]             const_b_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic [31:0]             prdata_q;
  logic                    pending_q;
  logic                    irq_q;
  logic                    chan_out_q;

  logic [2:0]              mode;
  logic                    pol;
  logic [1:0]              ina_sel;
  logic [1:0]              inb_sel;
  logic [1:0]              inc_sel;
  logic [2:0]              src;
  logic                    deb_en;
  logic                    int_en;

  assign mode    = ctrl_q[pwd_pkg::PWD_F_MODE_LO +: 3];
  assign pol     = ctrl_q[pwd_pkg::PWD_F_POL];
  assign ina_sel = ctrl_q[pwd_pkg::PWD_F_INA_LO +: 2];
  assign inb_sel = ctrl_q[pwd_pkg::PWD_F_INB_LO +: 2];
  assign inc_sel = ctrl_q[pwd_pkg::PWD_F_INC_LO +: 2];
  assign src     = ctrl_q[pwd_pkg::PWD_F_SRC_LO +: 3];
  assign deb_en  = ctrl_q[pwd_pkg::PWD_F_DEB];
  assign int_en  = ctrl_q[pwd_pkg::PWD_F_IE];

  logic                    wr_en;
  logic                    wr_trig;
  logic                    wr_ctrl;
  logic                    wr_const_a;
  logic                    wr_irq_clr;

  // a write takes effect in the access cycle in which pready is high
  assign wr_en      = psel & penable & pwrite & pready_q;
  assign wr_trig    = wr_en & (paddr == pwd_pkg::PWD_OFF_TRIG) & pwdata[0];
  assign wr_ctrl    = wr_en & (paddr == pwd_pkg::PWD_OFF_CTRL);
  assign wr_const_a = wr_en & (paddr == pwd_pkg::PWD_OFF_CONST_A);
  assign wr_irq_clr = wr_en & (paddr == pwd_pkg::PWD_OFF_IRQ) & pwdata[0];

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and debounce (bit 0 gate/reload, 1 clock/event, 2 trigger)

  logic [2:0]              pins;
  logic [2:0]              sync1_q;
  logic [2:0]              sync2_q;
  logic [2:0]              sync3_q;
  logic [2:0]              clean_q;
  logic [2:0]              filt_q;
  logic [2:0]              prev_q;
  logic [7:0]              deb_cnt_q [3];

  assign pins = {trigger_index_input, clock_event_input, gate_reload_input};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_q <= 3'h0;
    end else begin
      clean_q <= (sync2_q & sync3_q) | (clean_q & (sync2_q ^ sync3_q));
    end
  end

  // filter must see a level stable for the full window before passing it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        deb_cnt_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!deb_en || clean_q[i] == filt_q[i]) begin
          filt_q[i]    <= clean_q[i];
          deb_cnt_q[i] <= 8'h00;
        end else if (deb_cnt_q[i] == 8'(pwd_pkg::PWD_DEB_CYCLES - 1)) begin
          filt_q[i]    <= clean_q[i]; // [R3]
          deb_cnt_q[i] <= 8'h00;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= filt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // selected counting clock as a one-cycle enable

  logic [16:0]             acc_q;
  logic                    int_tick_q;
  logic [16:0]             acc_sum;
  logic                    ext_tick;
  logic                    clk_tick;

  // fractional accumulator: exact average rate, one pclk of jitter per tick
  assign acc_sum = acc_q + rate_khz(src, board_fast_q); // [R11] [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q      <= 17'h00000;
      int_tick_q <= 1'b0;
    end else if (acc_sum >= 17'(pwd_pkg::PWD_PCLK_KHZ)) begin
      acc_q      <= acc_sum - 17'(pwd_pkg::PWD_PCLK_KHZ);
      int_tick_q <= 1'b1;
    end else begin
      acc_q      <= acc_sum;
      int_tick_q <= 1'b0;
    end
  end

  // external clock: rising edges of the clock/event input
  assign ext_tick = (inb_sel == pwd_pkg::PWD_SEL_LOW || inb_sel == pwd_pkg::PWD_SEL_HIGH)
                    & filt_q[1] & ~prev_q[1]; // [R10]
  assign clk_tick = (src == pwd_pkg::PWD_SRC_EXT) ? ext_tick
                  : (src <= pwd_pkg::PWD_SRC_FASTEST) & int_tick_q; // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // trigger, gate, reload and index conditions

  logic                    ext_trig;
  logic                    trigger;
  logic                    gate_run;
  logic                    wd_reload;
  logic                    wd_continue;
  logic                    index_cond;

  assign ext_trig = ((inc_sel == pwd_pkg::PWD_SEL_LOW) & ~filt_q[2] & prev_q[2])
                  | ((inc_sel == pwd_pkg::PWD_SEL_HIGH) & filt_q[2] & ~prev_q[2]);
  assign trigger  = ext_trig | wr_trig; // [R13]

  assign gate_run = (ina_sel == pwd_pkg::PWD_SEL_LOW || ina_sel == pwd_pkg::PWD_SEL_HIGH)
                    ? sel_active(ina_sel, filt_q[0]) : 1'b1; // [R9]
  assign wd_reload = sel_active(ina_sel, filt_q[0]); // [R18]
  // trigger code 11 turns the trigger input into a continue/stop level
  assign wd_continue = (inc_sel != pwd_pkg::PWD_SEL_ALT) | filt_q[2]; // [R20]

  // index high with the gate/clock pair matching the code in bits 9:7
  always_comb begin
    index_cond = 1'b0;
    if (filt_q[2]) begin
      case (ctrl_q[9:7])
        3'h1:    index_cond = ~filt_q[0] & filt_q[1];
        3'h2:    index_cond = filt_q[0] & ~filt_q[1];
        3'h3:    index_cond = filt_q[0] & filt_q[1];
        3'h4:    index_cond = ~filt_q[0] & ~filt_q[1];
        default: index_cond = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter and state

  pwd_pkg::pwd_state_t     state_q;
  logic [16:0]             cnt_q;
  logic                    phase_q;
  logic                    act_q;
  logic                    event_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pwd_pkg::PWD_IDLE;
      cnt_q   <= 17'h00000;
      phase_q <= 1'b0;
      act_q   <= 1'b0;
      event_q <= 1'b0;
    end else begin
      event_q <= 1'b0;
      case (mode)
        pwd_pkg::PWD_MODE_PWM: begin
          if (trigger) begin
            // start in the delay phase timed by constant A
            state_q <= pwd_pkg::PWD_RUN; // [R4]
            phase_q <= 1'b0;
            act_q   <= 1'b0;
            cnt_q   <= load_val(const_a_q, src); // [R5] [R8]
          end else if (state_q == pwd_pkg::PWD_RUN && gate_run && clk_tick) begin // [R9]
            if (cnt_q <= 17'h00001) begin
              phase_q <= ~phase_q; // [R7]
              act_q   <= ~act_q;
              event_q <= 1'b1; // [R15]
              cnt_q   <= phase_q ? load_val(const_a_q, src)
                                 : load_val(const_b_q, src); // [R5] [R8]
            end else begin
              cnt_q <= cnt_q - 17'h00001; // [R7]
            end
          end
        end
        pwd_pkg::PWD_MODE_WDOG: begin
          if (trigger) begin
            if (cnt_q == 17'h00000) begin
              // never reloaded since last time-out
              state_q <= pwd_pkg::PWD_DONE; // [R17]
              act_q   <= 1'b0;
              event_q <= 1'b1;
            end else begin
              state_q <= pwd_pkg::PWD_RUN; // [R16]
              act_q   <= 1'b1;
            end
          end else if (state_q == pwd_pkg::PWD_RUN && wd_continue && clk_tick) begin // [R20]
            if (cnt_q <= 17'h00001) begin
              cnt_q   <= 17'h00000; // [R21]
              state_q <= pwd_pkg::PWD_DONE; // [R16]
              act_q   <= 1'b0;
              event_q <= 1'b1; // [R22]
            end else begin
              cnt_q <= cnt_q - 17'h00001; // [R21]
            end
          end
          // reloads override a decrement in the same cycle
          if (wr_const_a) begin
            cnt_q <= {1'b0, pwdata[15:0]}; // [R19]
          end else if (wd_reload) begin
            cnt_q <= {1'b0, const_a_q}; // [R18]
          end
        end
        pwd_pkg::PWD_MODE_QUAD: begin
          // count decoding lives elsewhere; only the output drive is here
          state_q <= pwd_pkg::PWD_IDLE;
          if (ctrl_q[11]) begin
            act_q <= index_cond; // [R2]
          end else if (ctrl_q[10]) begin
            act_q <= (cnt_q[15:0] == const_a_q); // [R1]
          end else begin
            act_q <= 1'b0;
          end
        end
        default: begin
          state_q <= pwd_pkg::PWD_IDLE;
          act_q   <= 1'b0;
        end
      endcase
    end
  end

  // inactive level is the opposite of the selected active level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_out_q <= 1'b1;
    end else begin
      chan_out_q <= act_q ? pol : ~pol; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt pending flag

  logic                    wd_expired;

  // clear is refused while the watchdog still sits at zero after time-out
  assign wd_expired = (mode == pwd_pkg::PWD_MODE_WDOG) && (state_q == pwd_pkg::PWD_DONE)
                      && (cnt_q == 17'h00000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
    end else if (event_q && int_en) begin
      pending_q <= 1'b1; // [R15] [R22]
    end else if (wr_irq_clr && !wd_expired) begin
      pending_q <= 1'b0; // [R22]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pending_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb register file

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      board_fast_q <= pwd_pkg::PWD_BOARD_RST;
      ctrl_q       <= pwd_pkg::PWD_CTRL_RST;
      const_a_q    <= pwd_pkg::PWD_CONST_RST;
      const_b_q    <= pwd_pkg::PWD_CONST_RST;
    end else if (wr_en) begin
      if (paddr == pwd_pkg::PWD_OFF_BOARD) begin
        board_fast_q <= pwdata[0]; // [R12]
      end else if (wr_ctrl) begin
        ctrl_q <= pwdata[15:0] & pwd_pkg::PWD_CTRL_WMASK;
      end else if (wr_const_a) begin
        const_a_q <= pwdata[15:0];
      end else if (paddr == pwd_pkg::PWD_OFF_CONST_B) begin
        const_b_q <= pwdata[15:0];
      end
    end
  end

  // answer prepared in the setup cycle, presented for one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == pwd_pkg::PWD_OFF_BOARD) begin
          prdata_q <= {31'h00000000, board_fast_q};
        end else if (paddr == pwd_pkg::PWD_OFF_TRIG) begin
          prdata_q <= 32'h00000000;
        end else if (paddr == pwd_pkg::PWD_OFF_CTRL) begin
          prdata_q <= {16'h0000, ctrl_q};
        end else if (paddr == pwd_pkg::PWD_OFF_CONST_A) begin
          prdata_q <= {16'h0000, const_a_q};
        end else if (paddr == pwd_pkg::PWD_OFF_CONST_B) begin
          prdata_q <= {16'h0000, const_b_q};
        end else if (paddr == pwd_pkg::PWD_OFF_COUNT) begin
          prdata_q <= {16'h0000, cnt_q[15:0]};
        end else if (paddr == pwd_pkg::PWD_OFF_IRQ) begin
          prdata_q <= {28'h0000000, wd_expired, state_q == pwd_pkg::PWD_RUN, act_q,
                       pending_q};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign prdata      = prdata_q;
  assign channel_out = chan_out_q;
  assign irq         = irq_q;

endmodule

/* File: pwd_pkg.sv */
package pwd_pkg;

  // bus and register map (byte addresses)
  localparam int unsigned   PWD_ADDR_W        = 8;
  localparam logic [7:0]    PWD_OFF_BOARD     = 8'h00;
  localparam logic [7:0]    PWD_OFF_TRIG      = 8'h04;
  localparam logic [7:0]    PWD_OFF_CTRL      = 8'h08;
  localparam logic [7:0]    PWD_OFF_CONST_A   = 8'h0c;
  localparam logic [7:0]    PWD_OFF_CONST_B   = 8'h10;
  localparam logic [7:0]    PWD_OFF_COUNT     = 8'h14;
  localparam logic [7:0]    PWD_OFF_IRQ       = 8'h18;

  // reset values
  localparam logic [15:0]   PWD_CTRL_RST      = 16'h0000;
  localparam logic [15:0]   PWD_CONST_RST     = 16'h0000;
  localparam logic          PWD_BOARD_RST     = 1'b0;
  // bit 14 is unused and reads as zero
  localparam logic [15:0]   PWD_CTRL_WMASK    = 16'hbfff;

  // channel_mode_control field positions
  localparam int unsigned   PWD_F_MODE_LO     = 0;
  localparam int unsigned   PWD_F_POL         = 3;
  localparam int unsigned   PWD_F_INA_LO      = 4;
  localparam int unsigned   PWD_F_INB_LO      = 6;
  localparam int unsigned   PWD_F_INC_LO      = 8;
  localparam int unsigned   PWD_F_SRC_LO      = 10;
  localparam int unsigned   PWD_F_DEB         = 13;
  localparam int unsigned   PWD_F_IE          = 15;

  // mode, selector and clock source codes
  localparam logic [2:0]    PWD_MODE_QUAD     = 3'h1;
  localparam logic [2:0]    PWD_MODE_PWM      = 3'h2;
  localparam logic [2:0]    PWD_MODE_WDOG     = 3'h3;
  localparam logic [1:0]    PWD_SEL_LOW       = 2'h1;
  localparam logic [1:0]    PWD_SEL_HIGH      = 2'h2;
  localparam logic [1:0]    PWD_SEL_ALT       = 2'h3;
  localparam logic [2:0]    PWD_SRC_FASTEST   = 3'h4;
  localparam logic [2:0]    PWD_SRC_EXT       = 3'h5;

  // timing
  localparam int unsigned   PWD_PCLK_KHZ      = 100000;
  localparam int unsigned   PWD_PCLK_NS       = 10;
  localparam int unsigned   PWD_BASE_KHZ      = 500;
  localparam int unsigned   PWD_DEBOUNCE_NS   = 2500;
  localparam int unsigned   PWD_DEB_CYCLES    = (PWD_DEBOUNCE_NS + PWD_PCLK_NS - 1) / PWD_PCLK_NS;

  typedef enum logic [1:0] {
    PWD_IDLE,
    PWD_RUN,
    PWD_DONE
  } pwd_state_t;

endpackage

/* File: pwd_field_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module pwd_field_model #(
  parameter int HALF = 10
) (
  // clock and bench commands
  input  wire logic clk,
  input  wire logic ext_run,
  input  wire logic gate_lvl,
  input  wire logic trig_lvl,
  // field pins
  output logic      gate_reload_input,
  output logic      clock_event_input,
  output logic      trigger_index_input
);
  int   cnt_q;
  logic tog_q;
  // clock stands still low outside a burst
  always_ff @(posedge clk) begin
    if (!ext_run) begin
      cnt_q <= 0;
      tog_q <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      tog_q <= !tog_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign clock_event_input   = ext_run && tog_q;
  assign gate_reload_input   = gate_lvl;
  assign trigger_index_input = trig_lvl;
endmodule

/* File: pwd_sva.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module pwd_sva (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // outputs
  input wire logic        channel_out,
  input wire logic        irq
);
  logic [15:0] ctrl_q;
  logic        run_q;
  logic        acc;
  assign acc = psel && penable && pready && pwrite;
  // shadow of the control word, as a host would see it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 16'h0000;
    end else if (acc && paddr == pwd_pkg::PWD_OFF_CTRL) begin
      ctrl_q <= pwdata[15:0] & pwd_pkg::PWD_CTRL_WMASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (acc && paddr == pwd_pkg::PWD_OFF_TRIG && pwdata[0]) begin
      run_q <= 1'b1;
    end else if (acc && paddr == pwd_pkg::PWD_OFF_CTRL) begin
      run_q <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
  err_only_a: assert property (pslverr |-> pready && paddr > 8'h18)
    else $error("error on mapped access");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  ctrl_read_a: assert property (pready && !pwrite && paddr == pwd_pkg::PWD_OFF_CTRL
    |-> prdata == {16'h0000, ctrl_q})
    else $error("control readback wrong");
  reset_out_a: assert property ($rose(presetn) |-> channel_out && !irq)
    else $error("output not inactive after reset");
  irq_mask_a: assert property (!irq && !ctrl_q[15] && !$past(ctrl_q[15]) |=> !irq)
    else $error("interrupt without enable");
  pwm_irq_a: assert property (ctrl_q[2:0] == pwd_pkg::PWD_MODE_PWM && ctrl_q[15] && run_q
    && $changed(channel_out) |-> ##[0:2] irq)
    else $error("no interrupt on pwm edge");
endmodule

bind pwd_channel pwd_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .channel_out(channel_out), .irq(irq));

/* File: testbench.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module testbench;
  localparam logic [7:0] BD = pwd_pkg::PWD_OFF_BOARD;
  localparam logic [7:0] TR = pwd_pkg::PWD_OFF_TRIG;
  localparam logic [7:0] CT = pwd_pkg::PWD_OFF_CTRL;
  localparam logic [7:0] CA = pwd_pkg::PWD_OFF_CONST_A;
  localparam logic [7:0] CB = pwd_pkg::PWD_OFF_CONST_B;
  localparam logic [7:0] CN = pwd_pkg::PWD_OFF_COUNT;
  localparam logic [7:0] CI = pwd_pkg::PWD_OFF_IRQ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, chan, err;
  logic        ext_run, gate_lvl, trig_lvl, gate_w, clk_w, trig_w;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, checks_done, n;

  pwd_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .gate_reload_input(gate_w), .clock_event_input(clk_w),
    .trigger_index_input(trig_w), .channel_out(chan), .irq(irq));
  pwd_field_model fm (.clk(pclk), .ext_run(ext_run), .gate_lvl(gate_lvl), .trig_lvl(trig_lvl),
    .gate_reload_input(gate_w), .clock_event_input(clk_w), .trigger_index_input(trig_w));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // request holds until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      chk(32'h0, 32'h1);
      finish_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_chg(output int cyc);
    logic old;
    old = chan;
    for (cyc = 1; cyc < 3000; cyc++) begin
      @(negedge pclk);
      if (chan !== old) return;
    end
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    ext_run <= 1'b0;
    gate_lvl <= 1'b1;
    trig_lvl <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checks_done = 0;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    do_reset();
    rdc(CT, 32'h0);
    wr(CT, 32'h0000ffff);
    rdc(CT, 32'h0000bfff);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    // external clock, 20 pclk period, active high
    do_reset();
    wr(CA, 32'h3);
    wr(CB, 32'h5);
    wr(CT, 32'h0000944a);
    ext_run <= 1'b1;
    wr(TR, 32'h1);
    wait_chg(n);
    chk(32'(chan), 32'h1);
    wait_chg(n);
    chk(32'(n >= 98 && n <= 102), 32'h1);
    chk(32'(irq), 32'h1);
    wait_chg(n);
    chk(32'(n >= 58 && n <= 62), 32'h1);
    $display("test pwm external clock done");
    // fast carrier, fastest internal clock
    do_reset();
    wr(BD, 32'h1);
    wr(CA, 32'h7);
    wr(CB, 32'h7);
    wr(CT, 32'h00001002);
    wr(TR, 32'h1);
    wait_chg(n);
    chk(32'(chan), 32'h0);
    wait_chg(n);
    chk(32'(n >= 23 && n <= 27), 32'h1);
    $display("test pwm fastest clock done");
    // gate held off, then released
    do_reset();
    wr(CA, 32'h2);
    wr(CB, 32'h2);
    wr(CT, 32'h00001012);
    wr(TR, 32'h1);
    n = 0;
    repeat (300) begin
      @(negedge pclk);
      if (chan !== 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    @(posedge pclk);
    gate_lvl <= 1'b0;
    wait_chg(n);
    chk(32'(n <= 60), 32'h1);
    $display("test pwm gate done");
    // debounce: short gate pulse filtered, long one passes
    do_reset();
    wr(CA, 32'h9);
    wr(CT, 32'h00003012);
    wr(TR, 32'h1);
    gate_lvl <= 1'b0;
    repeat (100) @(posedge pclk);
    gate_lvl <= 1'b1;
    repeat (20) @(posedge pclk);
    rdc(CN, 32'ha);
    gate_lvl <= 1'b0;
    wait_chg(n);
    chk(32'(n >= 350 && n <= 400), 32'h1);
    $display("test debounce done");
    do_reset();
    wr(CT, 32'h00000401);
    repeat (3) @(negedge pclk);
    chk(32'(chan), 32'h0);
    wr(CA, 32'h1);
    repeat (3) @(negedge pclk);
    chk(32'(chan), 32'h1);
    wr(CT, 32'h00000901);
    trig_lvl <= 1'b1;
    repeat (10) @(negedge pclk);
    chk(32'(chan), 32'h0);
    $display("test quadrature done");
    // watchdog, rising trigger, reload input active low
    do_reset();
    wr(CT, 32'h00009213);
    wr(CA, 32'h4);
    trig_lvl <= 1'b1;
    wait_chg(n);
    chk(32'(chan), 32'h0);
    wait_chg(n);
    chk(32'(n >= 36 && n <= 64), 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h1);
    rdc(CN, 32'h0);
    trig_lvl <= 1'b0;
    repeat (20) @(posedge pclk);
    trig_lvl <= 1'b1;
    repeat (20) @(posedge pclk);
    rdc(CN, 32'h0);
    wr(CI, 32'h1);
    repeat (3) @(negedge pclk);
    chk(32'(irq), 32'h1);
    @(posedge pclk);
    gate_lvl <= 1'b0;
    repeat (20) @(posedge pclk);
    gate_lvl <= 1'b1;
    rdc(CN, 32'h4);
    wr(CA, 32'h7);
    rdc(CN, 32'h7);
    wr(CI, 32'h1);
    repeat (3) @(negedge pclk);
    chk(32'(irq), 32'h0);
    $display("test watchdog done");
    finish_test();
  end
endmodule
